// *** tb/wake_line_model.sv ***
// External wake line: a switch or module driving the wake input.
// Assumes the bench calls its tasks; every change lands just after a clock edge.
`timescale 1ns/10ps

module wake_line_model (
  input  wire logic clk_i,
  output logic      pin_o
);
  initial pin_o = 1'h0;

  task automatic set_level(input logic lvl);
    @(posedge clk_i);
    pin_o <= lvl;
  endtask

  // Excursion and return; too short to pass the filter
  task automatic glitch(input int cycles);
    @(posedge clk_i);
    pin_o <= ~pin_o;
    repeat (cycles) @(posedge clk_i);
    pin_o <= ~pin_o;
  endtask
endmodule // wake_line_model

// *** tb/wake_pin_monitor_tb.sv ***
// Self-checking bench for the wake pin monitor.
// Assumes a shortened filter count so each edge settles in a few dozen cycles.
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module wake_pin_monitor_tb;
  import wake_pin_pkg::*;
  localparam int FILT = 8;
  typedef struct packed {
    chip_mode_e  mode;
    logic [3:0]  cfg;
    logic [3:0]  exp;
  } row_s;
  // cfg = {enable, mask_rise, mask_fall, undervolt}; exp = {flag, irq, sleep_exit, restart}
  localparam row_s ROWS [14] = '{
    '{MODE_NORMAL, 4'h8, 4'hC}, '{MODE_NORMAL, 4'h8, 4'hC}, '{MODE_STOP, 4'hC, 4'h8},
    '{MODE_SWFLASH, 4'hA, 4'h8}, '{MODE_NORMAL, 4'h0, 4'h0}, '{MODE_SLEEP, 4'h8, 4'h2},
    '{MODE_SLEEP, 4'h0, 4'h0}, '{MODE_FAILSAFE, 4'h0, 4'h1}, '{MODE_NORMAL, 4'h9, 4'h0},
    '{MODE_STOP, 4'hC, 4'hC}, '{MODE_FAILSAFE, 4'h1, 4'h0}, '{MODE_SLEEP, 4'h9, 4'h0},
    '{MODE_RESTART, 4'h8, 4'h0}, '{MODE_INIT, 4'h8, 4'h0}};
  logic       clk_sys = 1'h0;
  logic       rst = 1'h1;
  logic       pin;
  chip_mode_e mode = MODE_NORMAL;
  logic       uv = 1'h0;
  wake_ctrl_s ctrl = '0;
  logic       clr_a = 1'h0;
  logic       clr_b = 1'h0;
  logic       lvl_o, fa_o, fb_o, irq_o, sx_o, rs_o;
  logic       lvl_pin = 1'h0;
  logic       lvl_exp = 1'h0;
  logic       sx_seen, rs_seen;
  logic [1:0] fl_seen;
  row_s       r;
  int         bad_count = 0;
  int         samples_checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  wake_line_model u_wake_line_model (.clk_i(clk_sys), .pin_o(pin));

  wake_pin_monitor #(.FILT_CYCLES(FILT)) u_wake_pin_monitor (
    .CLK_SYS_I(clk_sys), .RST_I(rst), .WAKE_INPUT_I(pin), .CHIP_MODE_I(mode),
    .UNDERVOLT_OFF_I(uv), .CTRL_I(ctrl), .CLR_FLAG_A_I(clr_a), .CLR_FLAG_B_I(clr_b),
    .WAKE_PIN_LEVEL_BIT_O(lvl_o), .WAKE_PIN_FLAG_A_O(fa_o), .WAKE_PIN_FLAG_B_O(fb_o),
    .WAKE_IRQ_O(irq_o), .SLEEP_EXIT_O(sx_o), .RESTART_REQ_O(rs_o));

  task automatic results;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Controller clears both flags, as it must before any sleep command
  task automatic clear_flags;
    @(posedge clk_sys);
    clr_a <= 1'h1;
    clr_b <= 1'h1;
    @(posedge clk_sys);
    clr_a <= 1'h0;
    clr_b <= 1'h0;
  endtask

  // Filter plus sync is about a dozen cycles; 30 leaves margin
  task automatic settle;
    sx_seen = 1'h0;
    rs_seen = 1'h0;
    fl_seen = 2'h0;
    repeat (30) begin
      @(negedge clk_sys);
      sx_seen |= sx_o;
      rs_seen |= rs_o;
      fl_seen |= {fa_o, fb_o};
    end
  endtask

  initial begin
    @(negedge clk_sys);
    `CHK({lvl_o, fa_o, fb_o, irq_o, sx_o, rs_o}, 6'h00)
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (4) @(posedge clk_sys);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      @(posedge clk_sys);
      mode <= r.mode;
      {ctrl, uv} <= r.cfg;
      repeat (2) @(posedge clk_sys);
      lvl_pin = ~lvl_pin;
      u_wake_line_model.set_level(lvl_pin);
      settle();
      if (r.mode inside {MODE_NORMAL, MODE_STOP, MODE_SWFLASH}) lvl_exp = lvl_pin;
      `CHK({fa_o, fb_o}, lvl_pin ? {r.exp[3], 1'h0} : {1'h0, r.exp[3]})
      `CHK(irq_o, r.exp[2])
      `CHK(sx_seen, r.exp[1])
      `CHK(rs_seen, r.exp[0])
      if (!r.cfg[0]) `CHK(lvl_o, lvl_exp)
      clear_flags();
    end
    // Two short glitches one cycle apart must not add up
    @(posedge clk_sys);
    mode <= MODE_NORMAL;
    {ctrl, uv} <= 4'h8;
    u_wake_line_model.glitch(FILT - 2);
    u_wake_line_model.glitch(FILT - 2);
    settle();
    `CHK({fa_o, fb_o, lvl_o}, 3'h0)
    // Flag left pending when entering sleep
    u_wake_line_model.set_level(1'h1);
    settle();
    @(posedge clk_sys);
    mode <= MODE_SLEEP;
    repeat (3) @(negedge clk_sys);
    `CHK(sx_o, 1'h1)
    @(negedge clk_sys);
    `CHK(sx_o, 1'h1)
    clear_flags();
    repeat (3) @(negedge clk_sys);
    `CHK(sx_o, 1'h0)
    // Reset in mid-run with the pin high: level adopted, no false edge
    @(posedge clk_sys);
    rst <= 1'h1;
    mode <= MODE_NORMAL;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    settle();
    `CHK({fa_o, fb_o, lvl_o, fl_seen}, 5'h04)
    // Edge while both clears are held: the set still lands for one cycle
    @(posedge clk_sys);
    clr_a <= 1'h1;
    clr_b <= 1'h1;
    u_wake_line_model.set_level(1'h0);
    settle();
    `CHK(fl_seen, 2'h1)
    `CHK({fa_o, fb_o}, 2'h0)
    clear_flags();
    results();
  end
endmodule // wake_pin_monitor_tb

// *** verilog/wake_filter.sv ***
// Synchroniser and persistence filter for the wake input pin.
// Assumes an asynchronous pin; emits one-cycle edge pulses.
`timescale 1ns/10ps
`include "wake_pin_defines.svh"

module wake_filter
  import wake_pin_pkg::*;
#(
  parameter int FILT_CYCLES = `WAKE_FILTER_CYCLES,
  parameter int CNT_W       = $clog2(FILT_CYCLES + 1)
) (
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      pin_i,
  output wake_evt_s      evt_o
);

  typedef struct packed {
    logic             sync1;
    logic             sync2;
    logic [1:0]       prime;
    logic             level;
    logic             rise;
    logic             fall;
    logic [CNT_W-1:0] cnt;
  } filt_s;

  filt_s q;
  filt_s d;

  always_comb begin
    d       = q;
    d.sync1 = pin_i;
    d.sync2 = q.sync1;
    d.rise  = 1'b0;
    d.fall  = 1'b0;
    // Adopt the pin level after reset without reporting a false edge
    if (q.prime != `WAKE_PRIME_DONE) begin
      d.prime = q.prime + 2'h1;
      d.level = q.sync2;
      d.cnt   = '0;
    end else if (q.sync2 == q.level) begin
      d.cnt = '0;
    end else if (q.cnt == CNT_W'(FILT_CYCLES - 1)) begin
      d.level = q.sync2;
      d.rise  = q.sync2;
      d.fall  = !q.sync2;
      d.cnt   = '0;
    end else begin
      d.cnt = q.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign evt_o = '{level: q.level, rise: q.rise, fall: q.fall};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_revert_restart: assert property (
    (q.prime == `WAKE_PRIME_DONE) && (q.sync2 == q.level) |=> q.cnt == '0)
    else $error("filter count not cleared on revert");

  // Edges come at least FILT_CYCLES apart, so seven quiet cycles hold for counts of 8 and up
  a_edge_spacing: assert property (
    (q.rise || q.fall) |=> !(q.rise || q.fall) [*7])
    else $error("filtered edges too close together");

  a_edge_cause: assert property (
    (d.rise || d.fall) |-> q.cnt == CNT_W'(FILT_CYCLES - 1) && q.sync2 != q.level)
    else $error("edge reported before filter time");

endmodule // wake_filter

// *** verilog/wake_pin_defines.svh ***
// Timing counts and reset values for the wake pin monitor.
// Assumes the system clock runs at 40 MHz.
`ifndef WAKE_PIN_DEFINES_SVH
`define WAKE_PIN_DEFINES_SVH

`define CLK_SYS_PERIOD_NS     25
// Shortest accepted filter time; the longest is 25000 ns
`define WAKE_FILTER_MIN_NS    10000
`define WAKE_FILTER_CYCLES    ((`WAKE_FILTER_MIN_NS + `CLK_SYS_PERIOD_NS - 1) / `CLK_SYS_PERIOD_NS)
`define WAKE_PRIME_DONE       2'h3
`define WAKE_FLAG_RST         1'b0
`define WAKE_LEVEL_RST        1'b0

`endif

// *** verilog/wake_pin_monitor.sv ***
// Wake pin monitor: filters the wake input and turns changes into flags or wake requests.
// Assumes chip mode, undervoltage and control bits come from logic on CLK_SYS_I.
//
// Behaviour
// - Either filtered edge counts as wake event
// - Edge must persist for filter time
// - Enable bit switches pin wake capability
// - Undervoltage off ignores all wake events
// - Level bit tracks pin in Normal/Stop/Flash
// - Enabled edge in Sleep leaves Sleep
// - Any edge in Fail-Safe requests Restart
// - Enabled edge in active modes sets flag
// - Rise and fall interrupts masked separately
// - Pending flag wakes right after entering Sleep
`timescale 1ns/10ps
`include "wake_pin_defines.svh"

module wake_pin_monitor
  import wake_pin_pkg::*;
#(
  parameter int FILT_CYCLES = `WAKE_FILTER_CYCLES
) (
  input  wire logic  CLK_SYS_I,
  input  wire logic  RST_I,
  input  wire logic  WAKE_INPUT_I,
  input  chip_mode_e CHIP_MODE_I,
  input  wire logic  UNDERVOLT_OFF_I,
  input  wake_ctrl_s CTRL_I,
  input  wire logic  CLR_FLAG_A_I,
  input  wire logic  CLR_FLAG_B_I,
  output logic       WAKE_PIN_LEVEL_BIT_O,
  output logic       WAKE_PIN_FLAG_A_O,
  output logic       WAKE_PIN_FLAG_B_O,
  output logic       WAKE_IRQ_O,
  output logic       SLEEP_EXIT_O,
  output logic       RESTART_REQ_O
);

  typedef struct packed {
    logic level;
    logic flag_a;
    logic flag_b;
    logic irq;
    logic sleep_exit;
    logic restart;
  } mon_s;

  mon_s      q;
  mon_s      d;
  wake_evt_s evt;
  logic      active_mode;
  logic      any_edge;
  logic      set_a;
  logic      set_b;

  wake_filter #(
    .FILT_CYCLES (FILT_CYCLES)
  ) u_filter (
    .clk_i (CLK_SYS_I),
    .rst_i (RST_I),
    .pin_i (WAKE_INPUT_I),
    .evt_o (evt)
  );

  always_comb begin
    active_mode = 1'b0;
    case (CHIP_MODE_I)
      MODE_NORMAL, MODE_STOP, MODE_SWFLASH: active_mode = 1'b1;
      default: active_mode = 1'b0;
    endcase
  end

  // Below the undervoltage level the pin floats, so none of its edges may count; the level bit still follows it
  assign any_edge = (evt.rise || evt.fall) && !UNDERVOLT_OFF_I;
  assign set_a    = evt.rise && !UNDERVOLT_OFF_I && active_mode
                    && CTRL_I.wake_pin_enable_bit;
  assign set_b    = evt.fall && !UNDERVOLT_OFF_I && active_mode
                    && CTRL_I.wake_pin_enable_bit;

  always_comb begin
    d            = q;
    d.sleep_exit = 1'b0;
    d.restart    = 1'b0;
    if (active_mode) begin
      d.level = evt.level;
    end
    // Set beats clear so an edge in the clearing cycle is kept
    d.flag_a = set_a || (q.flag_a && !CLR_FLAG_A_I);
    d.flag_b = set_b || (q.flag_b && !CLR_FLAG_B_I);
    d.irq    = (d.flag_a && !CTRL_I.mask_rise)
               || (d.flag_b && !CTRL_I.mask_fall);
    if (!UNDERVOLT_OFF_I) begin
      case (CHIP_MODE_I)
        MODE_SLEEP: begin
          // Flags left set by the controller wake at once, by design
          d.sleep_exit = (any_edge && CTRL_I.wake_pin_enable_bit)
                         || q.flag_a || q.flag_b;
        end
        MODE_FAILSAFE: begin
          d.restart = any_edge;
        end
        default: begin
          d.sleep_exit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      q.level      <= `WAKE_LEVEL_RST;
      q.flag_a     <= `WAKE_FLAG_RST;
      q.flag_b     <= `WAKE_FLAG_RST;
      q.irq        <= 1'b0;
      q.sleep_exit <= 1'b0;
      q.restart    <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign WAKE_PIN_LEVEL_BIT_O = q.level;
  assign WAKE_PIN_FLAG_A_O    = q.flag_a;
  assign WAKE_PIN_FLAG_B_O    = q.flag_b;
  assign WAKE_IRQ_O           = q.irq;
  assign SLEEP_EXIT_O         = q.sleep_exit;
  assign RESTART_REQ_O        = q.restart;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  sequence s_rise_active;
    evt.rise && active_mode && CTRL_I.wake_pin_enable_bit && !UNDERVOLT_OFF_I;
  endsequence

  sequence s_fall_active;
    evt.fall && active_mode && CTRL_I.wake_pin_enable_bit && !UNDERVOLT_OFF_I;
  endsequence

  sequence s_edge_in_mode(chip_mode_e m);
    (evt.rise || evt.fall) && CHIP_MODE_I == m && !UNDERVOLT_OFF_I;
  endsequence

  a_rise_flag_set: assert property (s_rise_active |=> WAKE_PIN_FLAG_A_O)
    else $error("rising edge did not set flag a");

  a_fall_flag_set: assert property (s_fall_active |=> WAKE_PIN_FLAG_B_O)
    else $error("falling edge did not set flag b");

  a_flag_disabled: assert property (
    !CTRL_I.wake_pin_enable_bit && !WAKE_PIN_FLAG_A_O |=> !WAKE_PIN_FLAG_A_O)
    else $error("flag a set while pin wake disabled");

  a_uvoff_ignore: assert property (
    UNDERVOLT_OFF_I |=> !SLEEP_EXIT_O && !RESTART_REQ_O)
    else $error("wake acted on during undervoltage off");

  a_level_track: assert property (
    active_mode |=> WAKE_PIN_LEVEL_BIT_O == $past(evt.level))
    else $error("level bit does not follow filtered pin");

  a_sleep_exit: assert property (
    s_edge_in_mode(MODE_SLEEP) ##0 CTRL_I.wake_pin_enable_bit |=> SLEEP_EXIT_O)
    else $error("enabled edge in sleep did not exit");

  a_failsafe_restart: assert property (s_edge_in_mode(MODE_FAILSAFE) |=> RESTART_REQ_O)
    else $error("edge in fail-safe did not request restart");

  a_irq_mask: assert property (
    WAKE_IRQ_O |-> (WAKE_PIN_FLAG_A_O && !$past(CTRL_I.mask_rise))
                   || (WAKE_PIN_FLAG_B_O && !$past(CTRL_I.mask_fall)))
    else $error("interrupt raised for masked direction");

  a_pending_wake: assert property (
    CHIP_MODE_I == MODE_SLEEP && !UNDERVOLT_OFF_I && (WAKE_PIN_FLAG_A_O || WAKE_PIN_FLAG_B_O)
    |=> SLEEP_EXIT_O)
    else $error("pending flag did not wake from sleep");

  a_flag_clear_keep: assert property (
    CLR_FLAG_A_I && set_a |=> WAKE_PIN_FLAG_A_O)
    else $error("edge lost in clearing cycle");

  a_flag_a_clear: assert property (
    CLR_FLAG_A_I && !set_a |=> !WAKE_PIN_FLAG_A_O)
    else $error("flag a not cleared");

  a_flag_b_clear: assert property (
    CLR_FLAG_B_I && !set_b |=> !WAKE_PIN_FLAG_B_O)
    else $error("flag b not cleared");

  a_flag_b_disabled: assert property (
    !CTRL_I.wake_pin_enable_bit && !WAKE_PIN_FLAG_B_O |=> !WAKE_PIN_FLAG_B_O)
    else $error("flag b set while pin wake disabled");

  a_flag_inactive: assert property (
    !active_mode && !WAKE_PIN_FLAG_A_O && !WAKE_PIN_FLAG_B_O
    |=> !WAKE_PIN_FLAG_A_O && !WAKE_PIN_FLAG_B_O)
    else $error("flag set outside normal, stop or flash mode");

  a_irq_unmasked: assert property (
    (WAKE_PIN_FLAG_A_O && !$past(CTRL_I.mask_rise))
    || (WAKE_PIN_FLAG_B_O && !$past(CTRL_I.mask_fall)) |-> WAKE_IRQ_O)
    else $error("unmasked flag raised no interrupt");

  a_restart_cause: assert property (
    RESTART_REQ_O |-> $past(CHIP_MODE_I) == MODE_FAILSAFE && !$past(UNDERVOLT_OFF_I))
    else $error("restart requested outside fail-safe");

  // Edges are spaced by the filter, so a request never lasts two cycles
  a_restart_pulse: assert property (
    RESTART_REQ_O |=> !RESTART_REQ_O)
    else $error("restart request longer than one cycle");

  a_exit_cause: assert property (
    SLEEP_EXIT_O |-> $past(CHIP_MODE_I) == MODE_SLEEP)
    else $error("sleep exit outside sleep mode");

  a_exit_quiet: assert property (
    CHIP_MODE_I == MODE_SLEEP && !(evt.rise || evt.fall)
    && !WAKE_PIN_FLAG_A_O && !WAKE_PIN_FLAG_B_O |=> !SLEEP_EXIT_O)
    else $error("sleep exit with no edge and no flag");

  a_level_hold: assert property (
    !active_mode |=> $stable(WAKE_PIN_LEVEL_BIT_O))
    else $error("level bit moved outside normal, stop or flash mode");

endmodule // wake_pin_monitor

// *** verilog/wake_pin_pkg.sv ***
// Types shared by the wake pin monitor and its input filter.
// Assumes the chip mode arrives from the mode controller on the same clock.
package wake_pin_pkg;

  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE,
    MODE_SWFLASH
  } chip_mode_e;

  typedef struct packed {
    logic wake_pin_enable_bit;
    logic mask_rise;
    logic mask_fall;
  } wake_ctrl_s;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } wake_evt_s;

endpackage
